// ==== include/vrc_defs.svh ====
`ifndef VRC_DEFS_SVH
`define VRC_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define VRC_REF_CTRL_OFS   8'h9F
`define VRC_REF_CTRL_RST   8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VRC_BIT_POWER_ON   7
`define VRC_BIT_PIN_OE     6
`define VRC_BIT_RANGE_LOW  5
`define VRC_BIT_UNUSED     4
`define VRC_LEVEL_MSB      3
`define VRC_LEVEL_LSB      0
`define VRC_IMPL_MASK      8'hEF

// ----------------------------------------
// Ladder arithmetic
// ----------------------------------------
`define VRC_LEVELS         16
`define VRC_HIGH_BASE_32   6'h08
`define VRC_HIGH_DIV       8'h20
`define VRC_LOW_DIV        8'h18

`endif

// ==== include/vrc_pkg.sv ====
package vrc_pkg;

    typedef struct packed {
        logic       power_on;
        logic       pin_output_enable;
        logic       range_low;
        logic [3:0] level_select;
    } vrc_ctrl_t;

    // Output ratio of the ladder as numerator / denominator of supply
    typedef struct packed {
        logic       enabled;
        logic       drive_pin;
        logic [7:0] numerator;
        logic [7:0] denominator;
    } vrc_tap_t;

endpackage

// ==== src/vrc_ctrl.sv ====
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "vrc_defs.svh"

module vrc_ctrl
    import vrc_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst,
    // Register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    // Port direction bit of the analog pin, same clock
    input  wire logic               port_a_direction,
    // Sleep and wake indications
    input  wire logic               sleep_wake,
    // Ladder control
    output vrc_pkg::vrc_tap_t       ladder_tap,
    output logic                    analog_out_pin_oe
);
    import vrc_pkg::*;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a);
        return a == `VRC_REF_CTRL_OFS;
    endfunction

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       wr_hit;
    logic       rd_hit;
    vrc_ctrl_t  ctrl;
    vrc_tap_t   tap_d;
    vrc_tap_t   tap_q;

    assign wr_hit = reg_wr && hit(reg_addr);
    assign rd_hit = reg_rd && hit(reg_addr);

    assign ctrl_d  = wr_hit ? (reg_wdata & `VRC_IMPL_MASK) : ctrl_q;
    assign rdata_d = rd_hit ? ctrl_q : 8'h00;

    // fields come from own register only
    assign ctrl.power_on          = ctrl_q[`VRC_BIT_POWER_ON];
    assign ctrl.pin_output_enable = ctrl_q[`VRC_BIT_PIN_OE];
    assign ctrl.range_low         = ctrl_q[`VRC_BIT_RANGE_LOW];
    assign ctrl.level_select      = ctrl_q[`VRC_LEVEL_MSB:`VRC_LEVEL_LSB];

    // ----------------------------------------
    // Ladder tap
    // ----------------------------------------
    // sixteen taps per range
    assign tap_d.enabled     = ctrl.power_on;
    assign tap_d.drive_pin   = port_a_direction && ctrl.pin_output_enable;
    assign tap_d.numerator   = ctrl.range_low ? {4'h0, ctrl.level_select}
                                              : {2'h0, `VRC_HIGH_BASE_32} + {4'h0, ctrl.level_select};
    assign tap_d.denominator = ctrl.range_low ? `VRC_LOW_DIV : `VRC_HIGH_DIV;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q  <= `VRC_REF_CTRL_RST;
            rdata_q <= 8'h00;
            tap_q   <= '0;
        end else begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
            tap_q   <= tap_d;
        end
    end

    assign reg_rdata         = rdata_q;
    assign ladder_tap        = tap_q;
    assign analog_out_pin_oe = tap_q.drive_pin;

    // ----------------------------------------
    // Wake indication
    // ----------------------------------------
    // Wake comes from the sleep logic, retimed here
    logic       wake_meta_q;
    logic       wake_sync_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_meta_q <= 1'b0;
            wake_sync_q <= 1'b0;
        end else begin
            wake_meta_q <= sleep_wake;
            wake_sync_q <= wake_meta_q;
        end
    end

    // ----------------------------------------
    // Check sequences
    // ----------------------------------------
    // Accepted write to the control register
    sequence s_write_ctrl;
        !rst && reg_wr && hit(reg_addr);
    endsequence

    // Accepted read of the control register
    sequence s_read_ctrl;
        !rst && reg_rd && hit(reg_addr);
    endsequence

    // Write aimed at another register
    sequence s_write_other;
        !rst && reg_wr && !hit(reg_addr);
    endsequence

    // Read aimed at another register
    sequence s_read_other;
        !rst && reg_rd && !hit(reg_addr);
    endsequence

    // Out of reset for one more edge
    sequence s_running;
        !rst;
    endsequence

    // Tap shows the write of two edges back
    sequence s_tap_from_write;
        ladder_tap.enabled == $past(reg_wdata[`VRC_BIT_POWER_ON], 2)
        && ladder_tap.denominator == ($past(reg_wdata[`VRC_BIT_RANGE_LOW], 2) ? `VRC_LOW_DIV : `VRC_HIGH_DIV);
    endsequence

    // ----------------------------------------
    // Reset checks
    // ----------------------------------------
    AST_RESET_CLEARS: assert property (@(posedge mclk) rst |=> ctrl_q == `VRC_REF_CTRL_RST)
        else $error("control not cleared by reset");

    AST_RESET_OE_BIT: assert property (@(posedge mclk) rst |=> !ctrl_q[`VRC_BIT_PIN_OE])
        else $error("pin-output enable survived reset");

    AST_RESET_PIN: assert property (@(posedge mclk) rst |=> ##1 !analog_out_pin_oe)
        else $error("pin driven right after reset");

    AST_RESET_RANGE: assert property (@(posedge mclk) rst |=> !ctrl_q[`VRC_BIT_RANGE_LOW])
        else $error("range not high after reset");

    AST_RESET_LEVEL: assert property (@(posedge mclk) rst |=> ctrl_q[`VRC_LEVEL_MSB:`VRC_LEVEL_LSB] == 4'h0)
        else $error("level not cleared by reset");

    AST_RESET_OFF: assert property (@(posedge mclk) rst |=> ##1 !ladder_tap.enabled)
        else $error("ladder powered right after reset");

    // ----------------------------------------
    // Register checks
    // ----------------------------------------
    AST_UNUSED_ZERO: assert property (@(posedge mclk) disable iff (rst)
        s_read_ctrl |=> !reg_rdata[`VRC_BIT_UNUSED])
        else $error("unused bit read nonzero");

    AST_WRITE_STORES: assert property (@(posedge mclk) disable iff (rst)
        s_write_ctrl |=> ctrl_q == ($past(reg_wdata) & `VRC_IMPL_MASK))
        else $error("write not stored");

    AST_READ_BACK: assert property (@(posedge mclk) disable iff (rst)
        s_read_ctrl |=> reg_rdata == $past(ctrl_q))
        else $error("read data not the control register");

    AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
        !rst && !(reg_wr && hit(reg_addr)) |=> $stable(ctrl_q))
        else $error("control changed without write");

    AST_WAKE_KEEPS: assert property (@(posedge mclk) disable iff (rst)
        !rst && wake_sync_q && !reg_wr |=> $stable(ctrl_q))
        else $error("control changed on wake");

    AST_OTHER_WRITE: assert property (@(posedge mclk) disable iff (rst)
        s_write_other |=> $stable(ctrl_q))
        else $error("write to another register changed control");

    // ----------------------------------------
    // Read port checks
    // ----------------------------------------
    AST_RD_ONE: assert property (@(posedge mclk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    AST_OTHER_READ: assert property (@(posedge mclk) disable iff (rst)
        s_read_other |=> reg_rdata == 8'h00)
        else $error("read of another register not zero");

    // ----------------------------------------
    // Ladder checks
    // ----------------------------------------
    AST_HIGH_RATIO: assert property (@(posedge mclk) disable iff (rst)
        !rst && !ctrl_q[`VRC_BIT_RANGE_LOW] |=> ladder_tap.denominator == `VRC_HIGH_DIV
        && ladder_tap.numerator == {2'h0, `VRC_HIGH_BASE_32} + {4'h0, $past(ctrl_q[`VRC_LEVEL_MSB:`VRC_LEVEL_LSB])})
        else $error("high range ratio wrong");

    AST_LOW_RATIO: assert property (@(posedge mclk) disable iff (rst)
        !rst && ctrl_q[`VRC_BIT_RANGE_LOW] |=> ladder_tap.denominator == `VRC_LOW_DIV
        && ladder_tap.numerator == {4'h0, $past(ctrl_q[`VRC_LEVEL_MSB:`VRC_LEVEL_LSB])})
        else $error("low range ratio wrong");

    AST_ENABLE_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
        !rst |=> ladder_tap.enabled == $past(ctrl_q[`VRC_BIT_POWER_ON]))
        else $error("ladder enable not the power-on bit");

    AST_WRITE_TO_TAP: assert property (@(posedge mclk) disable iff (rst)
        s_write_ctrl ##1 s_running |=> s_tap_from_write)
        else $error("write did not reach the ladder tap");

    // ----------------------------------------
    // Pin checks
    // ----------------------------------------
    AST_PIN_DRIVE: assert property (@(posedge mclk) disable iff (rst)
        analog_out_pin_oe |-> $past(port_a_direction) && $past(ctrl_q[`VRC_BIT_PIN_OE]))
        else $error("pin driven without both enables");

    AST_PIN_ON: assert property (@(posedge mclk) disable iff (rst)
        !rst && port_a_direction && ctrl_q[`VRC_BIT_PIN_OE] |=> analog_out_pin_oe)
        else $error("pin not driven with both enables");

endmodule

// ==== test/vrc_ctrl_tb_top.sv ====
`timescale 1ns/100ps
module vrc_ctrl_tb_top;
    import vrc_pkg::*;
    logic       mclk, rst, reg_wr, reg_rd, port_a_direction, sleep_wake, analog_out_pin_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    vrc_tap_t   ladder_tap;
    int         n_errors, check_count;
    vrc_ctrl i_vrc_ctrl (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_direction(port_a_direction), .sleep_wake(sleep_wake),
        .ladder_tap(ladder_tap), .analog_out_pin_oe(analog_out_pin_oe));
    // ----
    // Helpers
    // ----
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    // Tap check one edge after control settles
    task automatic check_tap(input logic [7:0] c);
        vrc_tap_t e;
        @(posedge mclk);
        #1;
        e = {c[7], c[6] & port_a_direction, c[5] ? {4'h0, c[3:0]} : 8'h08 + c[3:0], c[5] ? 8'h18 : 8'h20};
        check_count++;
        if (ladder_tap !== e || analog_out_pin_oe !== e.drive_pin) begin
            n_errors++;
            $display("ERROR %0t tap %h exp %h", $time, ladder_tap, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        check_tap(8'h00);
        rd(8'h9F); check8(d, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_levels();
        for (int i = 0; i < 32; i++) begin
            wr(8'h9F, {3'b110 | 3'(i / 16), 1'b1, 4'(i)}); check_tap({3'b110 | 3'(i / 16), 1'b0, 4'(i)});
            rd(8'h9F); check8(d, {3'b110 | 3'(i / 16), 1'b0, 4'(i)});
        end
        $display("levels test done");
    endtask
    task automatic t_pin();
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) port_a_direction <= i[0];
            wr(8'h9F, {1'b1, i[1], 6'h03}); check_tap({1'b1, i[1], 6'h03});
        end
        $display("pin test done");
    endtask
    task automatic t_hold();
        wr(8'h9F, 8'hC5); wr(8'h9F, 8'h45); wr(8'h1F, 8'h00); wr(8'h9E, 8'hFF);
        @(posedge mclk) sleep_wake <= 1'b1;
        @(posedge mclk) sleep_wake <= 1'b0;
        rd(8'h9F); check8(d, 8'h45);
        check_tap(8'h45);
        rd(8'h1F); check8(d, 8'h00);
        $display("hold test done");
    endtask
    task automatic t_rerun();
        @(posedge mclk) rst <= 1'b1;
        @(posedge mclk) rst <= 1'b0;
        rd(8'h9F); check8(d, 8'h00);
        check_tap(8'h00);
        $display("second reset test done");
    endtask
    initial begin
        {rst, reg_wr, reg_rd, port_a_direction, sleep_wake, reg_addr, reg_wdata} = {1'b1, 20'h00001};
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        port_a_direction <= 1'b1;
        t_reset(); t_levels(); t_pin(); t_hold(); t_rerun();
        print_verdict();
    end
    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end
endmodule
